// ---- core/ssp_pkg.sv ----
package ssp_pkg;

  // ----------------------------------------------------------------
  // Serial word
  // ----------------------------------------------------------------
  localparam int unsigned SHIFT_WIDTH = 24;
  localparam int unsigned ADDR_WIDTH  = 2;
  localparam logic [SHIFT_WIDTH-1:0] SHIFT_RESET = 24'h000000;

  // Word targets, selected by the two low bits of a loaded word
  localparam logic [1:0] ADDR_FREQ   = 2'h0;
  localparam logic [1:0] ADDR_CONFIG = 2'h1;
  localparam logic [1:0] ADDR_PIN    = 2'h2;

  // ----------------------------------------------------------------
  // Field positions inside a loaded word
  // ----------------------------------------------------------------
  localparam int unsigned FREQ_LSB    = 2;   // 21-bit frequency word at [22:2]
  localparam int unsigned FREQ_WIDTH  = 21;
  localparam int unsigned FREQ_FAST   = 23;  // fast-settle request with the retune
  localparam int unsigned CFG_MODW    = 2;   // 1: 22-bit modulus, 0: 12-bit
  localparam int unsigned CFG_ORD_LSB = 3;   // modulator order, 3 bits
  localparam int unsigned PIN_MODE_LSB = 2;  // fast-settle pin mode, 2 bits
  localparam int unsigned PIN_PD      = 4;   // software power-down, ORed with chip enable low into power_down_o

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [2:0] ORDER_MAX   = 3'h4;
  localparam logic [2:0] ORDER_RESET = 3'h3;
  localparam logic [20:0] FREQ_RESET = 21'h000000;

  // Serial clock limit and its sampling budget at 25 MHz
  localparam int unsigned SCLK_MAX_KHZ = 20000;
  localparam int unsigned SYS_KHZ      = 25000;
  localparam int unsigned FAST_CYCLES  = 16;

  typedef enum logic [1:0] {
    PIN_FAST  = 2'b00,
    PIN_LOW   = 2'b01,
    PIN_HIGH  = 2'b10,
    PIN_FLOAT = 2'b11
  } ssp_pin_mode_type;

  typedef enum logic [0:0] {
    MOD_12 = 1'b0,
    MOD_22 = 1'b1
  } ssp_mod_width_type;

endpackage

// ---- core/ssp_port.sv ----
`timescale 1ns/1ns
module ssp_port
  import ssp_pkg::*;
(
  // System
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // Serial programming pins
  input  wire logic        serial_clock_i,
  input  wire logic        serial_data_i,
  input  wire logic        load_strobe_i,
  input  wire logic        chip_enable_i,
  input  wire logic        ref_buffer_enable_i,
  // Analog status from the loop
  input  wire logic        fast_settle_busy_i,
  // Working configuration
  output logic [20:0]      freq_word_o,
  output logic             freq_update_o,
  output logic             modulus_22_o,
  output logic [2:0]       mod_order_o,
  output logic             power_down_o,
  // Pins driven by the block
  output logic             ref_buffer_output_o,
  output logic             fast_settle_output_o,
  output logic             fast_settle_output_oe_n_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0]             sclk_sync_ff;
  logic [1:0]             sdat_sync_ff;
  logic [1:0]             load_sync_ff;
  logic [1:0]             ce_sync_ff;
  logic [1:0]             oscen_sync_ff;
  logic [1:0]             busy_sync_ff;
  logic                   sclk_prev_ff;
  logic                   load_prev_ff;

  // Two stages each; only the second stage is read by any logic
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sclk_sync_ff  <= 2'h0;
      sdat_sync_ff  <= 2'h0;
      load_sync_ff  <= 2'h0;
      ce_sync_ff    <= 2'h0;
      oscen_sync_ff <= 2'h0;
      busy_sync_ff  <= 2'h0;
      sclk_prev_ff  <= 1'b0;
      load_prev_ff  <= 1'b0;
    end else begin
      sclk_sync_ff  <= {sclk_sync_ff[0], serial_clock_i};
      sdat_sync_ff  <= {sdat_sync_ff[0], serial_data_i};
      load_sync_ff  <= {load_sync_ff[0], load_strobe_i};
      ce_sync_ff    <= {ce_sync_ff[0], chip_enable_i};
      oscen_sync_ff <= {oscen_sync_ff[0], ref_buffer_enable_i};
      busy_sync_ff  <= {busy_sync_ff[0], fast_settle_busy_i};
      sclk_prev_ff  <= sclk_sync_ff[1];
      load_prev_ff  <= load_sync_ff[1];
    end
  end

  // Edge detection works on the synchronised copies only.
  // Limitation: at 25 MHz sampling the serial clock must hold each level for
  // at least two system cycles, so the usable rate is below the pin limit.
  // serial rate bound
  // The host must stay inside both limits; the sampling bound is the tighter one.
  wire sclk_rise = sclk_sync_ff[1] & ~sclk_prev_ff;
  wire load_rise = load_sync_ff[1] & ~load_prev_ff;

  // ----------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------
  logic [SHIFT_WIDTH-1:0] shift_ff;
  wire  [SHIFT_WIDTH-1:0] nxt_shift = {shift_ff[SHIFT_WIDTH-2:0], sdat_sync_ff[1]};

  always_ff @(posedge clk_sys_i) begin
    if (reset_i)
      shift_ff <= SHIFT_RESET;
    else if (sclk_rise)
      shift_ff <= nxt_shift;
  end

  // ----------------------------------------------------------------
  // Load decode
  // ----------------------------------------------------------------
  wire [1:0] word_addr   = shift_ff[ADDR_WIDTH-1:0];
  wire       load_freq   = load_rise & (word_addr == ADDR_FREQ);
  wire       load_cfg    = load_rise & (word_addr == ADDR_CONFIG);
  wire       load_pin    = load_rise & (word_addr == ADDR_PIN);
  wire [2:0] req_order   = shift_ff[CFG_ORD_LSB +: 3];
  // Orders above fourth are clamped rather than ignored
  wire [2:0] nxt_order   = (req_order > ORDER_MAX) ? ORDER_MAX : req_order;

  logic [20:0]      freq_ff;
  logic             freq_upd_ff;
  logic             fast_req_ff;
  logic             mod22_ff;
  logic [2:0]       order_ff;
  ssp_pin_mode_type pin_mode_ff;
  logic             sw_pd_ff;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      freq_ff     <= FREQ_RESET;
      freq_upd_ff <= 1'b0;
      fast_req_ff <= 1'b0;
    end else begin
      freq_upd_ff <= load_freq;
      // one word retunes and arms fast-settle
      if (load_freq) begin
        freq_ff     <= shift_ff[FREQ_LSB +: FREQ_WIDTH];
        fast_req_ff <= shift_ff[FREQ_FAST];
      end else if (fast_req_ff && busy_sync_ff[1] == 1'b0 && !freq_upd_ff) begin
        fast_req_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      mod22_ff    <= MOD_12;
      order_ff    <= ORDER_RESET;
      pin_mode_ff <= PIN_FAST;
      sw_pd_ff    <= 1'b0;
    end else begin
      if (load_cfg) begin
        mod22_ff <= shift_ff[CFG_MODW];
        order_ff <= nxt_order;
      end
      if (load_pin) begin
        pin_mode_ff <= ssp_pin_mode_type'(shift_ff[PIN_MODE_LSB +: 2]);
        sw_pd_ff    <= shift_ff[PIN_PD];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  // chip enable low powers down
  wire nxt_pd     = ~ce_sync_ff[1] | sw_pd_ff;
  wire nxt_refbuf = oscen_sync_ff[1] | ~nxt_pd;
  wire nxt_fs_out = (pin_mode_ff == PIN_HIGH) |
                    ((pin_mode_ff == PIN_FAST) & fast_req_ff);
  wire nxt_fs_oen = (pin_mode_ff == PIN_FLOAT);

  // Registered so every pin comes straight from a flip-flop
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      power_down_o              <= 1'b1;
      ref_buffer_output_o       <= 1'b0;
      fast_settle_output_o      <= 1'b0;
      fast_settle_output_oe_n_o <= 1'b0;
    end else begin
      power_down_o              <= nxt_pd;
      ref_buffer_output_o       <= nxt_refbuf;
      fast_settle_output_o      <= nxt_fs_out;
      fast_settle_output_oe_n_o <= nxt_fs_oen;
    end
  end

  assign freq_word_o   = freq_ff;
  assign freq_update_o = freq_upd_ff;
  assign modulus_22_o  = mod22_ff;
  assign mod_order_o   = order_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  shift_in_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    sclk_rise |=> shift_ff[0] == $past(sdat_sync_ff[1]))
    else $error("shift register missed a serial bit");

  load_word_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    load_freq |=> freq_ff == $past(shift_ff[FREQ_LSB +: FREQ_WIDTH]) && freq_update_o)
    else $error("frequency word not latched on strobe");

  ce_down_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !ce_sync_ff[1] |=> power_down_o)
    else $error("chip enable low did not power down");

  ref_on_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    oscen_sync_ff[1] |=> ref_buffer_output_o)
    else $error("reference buffer not forced on");

  pin_float_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    pin_mode_ff == PIN_FLOAT |=> fast_settle_output_oe_n_o)
    else $error("fast-settle pin driven in float mode");

  single_word_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    load_freq && shift_ff[FREQ_FAST] && pin_mode_ff == PIN_FAST
      |=> ##1 fast_settle_output_o)
    else $error("single word did not start fast-settle");

  mod_width_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    load_cfg |=> modulus_22_o == $past(shift_ff[CFG_MODW]))
    else $error("modulus width not taken");

  order_max_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    mod_order_o <= ORDER_MAX)
    else $error("modulator order above fourth");

  upd_pulse_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    freq_update_o |=> !freq_update_o)
    else $error("frequency update pulse longer than one cycle");

  pin_low_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    pin_mode_ff == PIN_LOW |=> !fast_settle_output_o && !fast_settle_output_oe_n_o)
    else $error("fast-settle pin not driven low in low mode");

endmodule // ssp_port

// ---- verification/ssp_host_model.sv ----
`timescale 1ns/1ns
module ssp_host_model (
  // System
  input  wire logic clk_sys_i,
  // Serial programming pins
  output logic      serial_clock_o,
  output logic      serial_data_o,
  output logic      load_strobe_o
);
  // Idle levels: clock and strobe low
  initial begin
    serial_clock_o = 1'b0;
    serial_data_o  = 1'b0;
    load_strobe_o  = 1'b0;
  end

  // Wait n edges, then step just off the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask

  // slow serial clock
  // Halves of 120 ns keep clear of the two-cycle sampling minimum
  task automatic send_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      serial_data_o  = w[i];
      step(3);
      serial_clock_o = 1'b1;
      step(3);
      serial_clock_o = 1'b0;
    end
    // Data no longer held: show the inverse so a stale bit cannot pass
    serial_data_o = ~w[0];
    load_strobe_o = 1'b1;
    step(3);
    load_strobe_o = 1'b0;
    step(3);
  endtask
endmodule // ssp_host_model

// ---- verification/tb_ssp_port.sv ----
`timescale 1ns/1ns
module tb_ssp_port;
  import ssp_pkg::*;
  logic        clk_sys_i;
  logic        reset_i;
  logic        sclk;
  logic        sdat;
  logic        strobe;
  logic        ce;
  logic        ref_en;
  logic        busy;
  logic [20:0] freq_word_o;
  logic        freq_update_o;
  logic        modulus_22_o;
  logic [2:0]  mod_order_o;
  logic        power_down_o;
  logic        ref_out;
  logic        fs_out;
  logic        fs_oe_n;
  int          error_cnt;
  int          n_compared;
  int          upd_cnt;

  ssp_host_model i_ssp_host_model (.clk_sys_i(clk_sys_i), .serial_clock_o(sclk),
    .serial_data_o(sdat), .load_strobe_o(strobe));
  ssp_port i_ssp_port (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .serial_clock_i(sclk),
    .serial_data_i(sdat), .load_strobe_i(strobe), .chip_enable_i(ce),
    .ref_buffer_enable_i(ref_en), .fast_settle_busy_i(busy), .freq_word_o(freq_word_o),
    .freq_update_o(freq_update_o), .modulus_22_o(modulus_22_o), .mod_order_o(mod_order_o),
    .power_down_o(power_down_o), .ref_buffer_output_o(ref_out),
    .fast_settle_output_o(fs_out), .fast_settle_output_oe_n_o(fs_oe_n));

  // 25 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // Count update pulses; a pulse longer than one cycle counts once for every cycle it is high
  always @(posedge clk_sys_i) begin
    if (freq_update_o === 1'b1) upd_cnt++;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // One word retunes and starts fast-settle
  task automatic sc_freq(input logic [20:0] f);
    int n;
    n = upd_cnt;
    i_ssp_host_model.send_word({1'b1, f, ADDR_FREQ});
    check(32'(upd_cnt), 32'(n + 1));
    check(32'(freq_word_o), 32'(f));
    check(32'(fs_out), 32'h1);
    busy = 1'b0;
    for (n = 0; n < 8 && fs_out !== 1'b0; n++) step(1);
    check(32'(fs_out), 32'h0);
    busy = 1'b1;
    if (fs_out !== 1'b0) stop_test();
  endtask

  // Every modulus width and order, orders above four clamp
  task automatic sc_cfg();
    int n;
    n = upd_cnt;
    for (int o = 0; o < 8; o++) begin
      i_ssp_host_model.send_word({18'h0, 3'(o), 1'(o), ADDR_CONFIG});
      check(32'(modulus_22_o), 32'(o % 2));
      check(32'(mod_order_o), 32'((o > 4) ? 4 : o));
    end
    check(32'(upd_cnt), 32'(n));
  endtask

  // Pin modes, then a word to the unused address is ignored
  task automatic sc_pin();
    ssp_pin_mode_type m [3] = '{PIN_LOW, PIN_HIGH, PIN_FLOAT};
    foreach (m[i]) begin
      i_ssp_host_model.send_word({19'h0, 1'b0, m[i], ADDR_PIN});
      check(32'(fs_oe_n), 32'(m[i] == PIN_FLOAT));
      if (m[i] != PIN_FLOAT) check(32'(fs_out), 32'(m[i] == PIN_HIGH));
    end
    i_ssp_host_model.send_word({19'h0, 1'b0, PIN_LOW, 2'h3});
    check(32'(fs_oe_n), 32'h1);
    i_ssp_host_model.send_word({19'h0, 1'b0, PIN_FAST, ADDR_PIN});
  endtask

  // Hardware and software power-down against the buffer enable pin
  task automatic sc_power();
    ce = 1'b0;
    step(4);
    check(32'({power_down_o, ref_out}), 32'h2);
    ref_en = 1'b1;
    step(4);
    check(32'(ref_out), 32'h1);
    ce = 1'b1;
    ref_en = 1'b0;
    i_ssp_host_model.send_word({19'h0, 1'b1, PIN_FAST, ADDR_PIN});
    check(32'({power_down_o, ref_out}), 32'h2);
    ref_en = 1'b1;
    step(4);
    check(32'(ref_out), 32'h1);
    ref_en = 1'b0;
    i_ssp_host_model.send_word({19'h0, 1'b0, PIN_FAST, ADDR_PIN});
    check(32'({power_down_o, ref_out}), 32'h1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    error_cnt = 0;
    n_compared = 0;
    upd_cnt = 0;
    reset_i = 1'b1;
    ce = 1'b1;
    ref_en = 1'b0;
    busy = 1'b1;
    step(2);
    check(32'({power_down_o, ref_out}), 32'h2);
    reset_i = 1'b0;
    step(4);
    check(32'({freq_word_o, modulus_22_o, mod_order_o}), {7'h0, 21'h0, 1'b0, ORDER_RESET});
    sc_freq(21'h1fffff);
    sc_freq(21'h000001);
    sc_cfg();
    sc_pin();
    sc_power();
    stop_test();
  end
endmodule // tb_ssp_port
